/* File: rtl/tig_top.sv */
// Three-channel timer interrupt enable block with its register port.
`timescale 1ns/1ps
`include "tig_cfg.svh"


module tig_top #(
  parameter int CH_W = 16
) (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic [`TIG_ADDR_W-1:0]   addr,
  input  wire logic [7:0]               wdata,
  input  wire logic                     wr,
  input  wire logic                     rd,
  output logic [7:0]                    rdata,
  input  wire tig_pkg::tig_step_t       step [3],
  input  wire logic [2:0]               cap_a,
  input  wire logic [2:0]               cap_b,
  input  wire logic                     cap_c,
  input  wire logic                     cap_d,
  output logic [2:0]                    conv_start_req,
  output logic [2:0]                    overflow_irq,
  output logic [2:0]                    underflow_irq,
  output logic [2:0]                    match_a_irq,
  output logic [2:0]                    match_b_irq,
  output logic                          match_c_irq,
  output logic                          match_d_irq,
  output logic                          irq
);
  import tig_pkg::*;

  logic [7:0]      ien   [3];
  logic [7:0]      stat  [3];
  logic [CH_W-1:0] cnt   [3];
  logic [2:0]      ovf_set;
  logic [2:0]      unf_set;
  logic [2:0]      c_irq;
  logic [2:0]      d_irq;
  logic [2:0]      ien_we;
  logic [2:0]      stat_we;
  logic [2:0]      stat_re;
  logic [5:0]      ev_set;
  logic [5:0]      istat_q;
  logic [5:0]      imask_q;
  logic [7:0]      rdata_q;

  // ==========================================================================
  // Address decode
  // ==========================================================================
  assign ien_we  = {wr && addr == `TIG_IEN2_OFS, wr && addr == `TIG_IEN1_OFS,
                    wr && addr == `TIG_IEN0_OFS};
  assign stat_we = {wr && addr == `TIG_STAT2_OFS, wr && addr == `TIG_STAT1_OFS,
                    wr && addr == `TIG_STAT0_OFS};
  assign stat_re = {rd && addr == `TIG_STAT2_OFS, rd && addr == `TIG_STAT1_OFS,
                    rd && addr == `TIG_STAT0_OFS};

  // ==========================================================================
  // Channels
  // ==========================================================================
  // one tig_chan instance per channel
  genvar g;
  generate
    for (g = 0; g < `TIG_NUM_CH; g++) begin : g_ch
      tig_chan #(
        .CH_W     (CH_W),
        .WMASK    (g == 0 ? `TIG_WMASK_CH0 : `TIG_WMASK_CH12),
        .STAT_FIX (g == 0 ? `TIG_STAT_FIX_CH0 : `TIG_STAT_FIX_CH12)
      ) u_chan (
        .clk            (clk),
        .rst_b          (rst_b),
        .step           (step[g]),
        .cap_a          (cap_a[g]),
        .cap_b          (cap_b[g]),
        .cap_c          (g == 0 ? cap_c : 1'b0),
        .cap_d          (g == 0 ? cap_d : 1'b0),
        .ien_we         (ien_we[g]),
        .stat_we        (stat_we[g]),
        .stat_re        (stat_re[g]),
        .wdata          (wdata),
        .ien            (ien[g]),
        .stat           (stat[g]),
        .cnt            (cnt[g]),
        .ovf_set        (ovf_set[g]),
        .unf_set        (unf_set[g]),
        .conv_start_req (conv_start_req[g]),
        .overflow_irq   (overflow_irq[g]),
        .underflow_irq  (underflow_irq[g]),
        .match_a_irq    (match_a_irq[g]),
        .match_b_irq    (match_b_irq[g]),
        .match_c_irq    (c_irq[g]),
        .match_d_irq    (d_irq[g])
      );
    end
  endgenerate

  // Channels 1 and 2 have no C or D sources, so only channel 0 drives these.
  assign match_c_irq = c_irq[0];
  assign match_d_irq = d_irq[0];

  // ==========================================================================
  // Wrap event summary interrupt
  // ==========================================================================
  // Bits 2:0 collect overflow wraps, bits 5:3 underflow wraps, per channel.
  assign ev_set = {unf_set, ovf_set};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      istat_q <= 6'h00;
    end else if (rd && addr == `TIG_ISTAT_OFS) begin
      istat_q <= ev_set;
    end else begin
      istat_q <= istat_q | ev_set;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      imask_q <= 6'h00;
    end else if (wr && addr == `TIG_IMASK_OFS) begin
      imask_q <= wdata[5:0];
    end
  end

  assign irq = |(istat_q & imask_q);

  // ==========================================================================
  // Read data
  // ==========================================================================
  // The counter byte shows only the low byte; the port is eight bits wide.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        `TIG_IEN0_OFS:  rdata_q <= ien[0];
        `TIG_IEN1_OFS:  rdata_q <= ien[1];
        `TIG_IEN2_OFS:  rdata_q <= ien[2];
        `TIG_STAT0_OFS: rdata_q <= stat[0];
        `TIG_STAT1_OFS: rdata_q <= stat[1];
        `TIG_STAT2_OFS: rdata_q <= stat[2];
        `TIG_CNT0_OFS:  rdata_q <= cnt[0][7:0];
        `TIG_CNT1_OFS:  rdata_q <= cnt[1][7:0];
        `TIG_CNT2_OFS:  rdata_q <= cnt[2][7:0];
        `TIG_ISTAT_OFS: rdata_q <= {2'b00, istat_q};
        `TIG_IMASK_OFS: rdata_q <= {2'b00, imask_q};
        default:        rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata = rdata_q;

endmodule

/* File: rtl/tig_cfg.svh */
// Register offsets, field positions, reset values and counts of the timer interrupt enable block.
`ifndef TIG_CFG_SVH
`define TIG_CFG_SVH

// ==========================================================================
// Register map
// ==========================================================================
`define TIG_ADDR_W        4
`define TIG_IEN0_OFS      4'h0
`define TIG_IEN1_OFS      4'h1
`define TIG_IEN2_OFS      4'h2
`define TIG_STAT0_OFS     4'h4
`define TIG_STAT1_OFS     4'h5
`define TIG_STAT2_OFS     4'h6
`define TIG_CNT0_OFS      4'h8
`define TIG_CNT1_OFS      4'h9
`define TIG_CNT2_OFS      4'hA
`define TIG_ISTAT_OFS     4'hC
`define TIG_IMASK_OFS     4'hD

// ==========================================================================
// Enable register fields
// ==========================================================================
`define TIG_B_CONV        7
`define TIG_B_RSV6        6
`define TIG_B_UNF         5
`define TIG_B_OVF         4
`define TIG_B_MD          3
`define TIG_B_MC          2
`define TIG_B_MB          1
`define TIG_B_MA          0

// Writable bits and fixed-one bits of each channel's enable register.
`define TIG_WMASK_CH0     8'h9F
`define TIG_WMASK_CH12    8'hB3
`define TIG_FIXED_ONE     8'h40
`define TIG_IEN_RESET     8'h40

// Status register: bit 6 reads one; channel 0 also reads one at bit 7.
`define TIG_STAT_FIX_CH0  8'hC0
`define TIG_STAT_FIX_CH12 8'h40
`define TIG_STAT_RESET    8'h00

`define TIG_CNT_MAX       16'hFFFF
`define TIG_CNT_ZERO      16'h0000
`define TIG_NUM_CH        3
`define TIG_NUM_EV        3

`endif

/* File: rtl/tig_pkg.sv */
// Types shared by the timer interrupt enable block.
package tig_pkg;

  typedef logic [7:0]  tig_byte_t;
  typedef logic [15:0] tig_cnt_t;

  // Counter step direction applied in a cycle.
  typedef enum logic [1:0] {
    TIG_STEP_NONE = 2'b00,
    TIG_STEP_UP   = 2'b01,
    TIG_STEP_DOWN = 2'b10
  } tig_step_t;

endpackage

/* File: rtl/tig_chan.sv */
// One timer channel: counter, status flags and interrupt-enable gating.
`timescale 1ns/1ps
`include "tig_cfg.svh"

module tig_chan #(
  parameter int        CH_W      = 16,
  parameter logic [7:0] WMASK    = `TIG_WMASK_CH0,
  parameter logic [7:0] STAT_FIX = `TIG_STAT_FIX_CH0
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire tig_pkg::tig_step_t step,
  input  wire logic              cap_a,
  input  wire logic              cap_b,
  input  wire logic              cap_c,
  input  wire logic              cap_d,
  input  wire logic              ien_we,
  input  wire logic              stat_we,
  input  wire logic              stat_re,
  input  wire logic [7:0]        wdata,
  output logic [7:0]             ien,
  output logic [7:0]             stat,
  output logic [CH_W-1:0]        cnt,
  output logic                   ovf_set,
  output logic                   unf_set,
  output logic                   conv_start_req,
  output logic                   overflow_irq,
  output logic                   underflow_irq,
  output logic                   match_a_irq,
  output logic                   match_b_irq,
  output logic                   match_c_irq,
  output logic                   match_d_irq
);
  import tig_pkg::*;

  logic [7:0]      ien_q;
  logic [7:0]      flag_q;
  logic [7:0]      armed_q;
  logic [7:0]      set_v;
  logic [CH_W-1:0] cnt_q;

  // ==========================================================================
  // Counter and wrap events
  // ==========================================================================
  // wrap detection
  assign ovf_set = (step == TIG_STEP_UP) && (cnt_q == {CH_W{1'b1}});
  assign unf_set = (step == TIG_STEP_DOWN) && (cnt_q == {CH_W{1'b0}});

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (step == TIG_STEP_UP) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (step == TIG_STEP_DOWN) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // ==========================================================================
  // Enable register
  // ==========================================================================
  // fixed and reserved bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ien_q <= `TIG_IEN_RESET;
    end else if (ien_we) begin
      ien_q <= (wdata & WMASK) | `TIG_FIXED_ONE;
    end
  end

  // ==========================================================================
  // Status flags
  // ==========================================================================
  always_comb begin
    set_v                = 8'h00;
    set_v[`TIG_B_OVF]    = ovf_set;
    set_v[`TIG_B_UNF]    = unf_set;
    set_v[`TIG_B_MD]     = cap_d;
    set_v[`TIG_B_MC]     = cap_c;
    set_v[`TIG_B_MB]     = cap_b;
    set_v[`TIG_B_MA]     = cap_a;
    set_v                = set_v & WMASK & 8'h3F;
  end

  // A flag is armed by a read that sees it at one; a later zero write clears
  // only armed flags. A set in the same cycle wins over the clear.
  // read then write zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= `TIG_STAT_RESET;
    end else begin
      flag_q <= set_v | (stat_we ? (flag_q & ~(armed_q & ~wdata)) : flag_q);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_q <= 8'h00;
    end else if (stat_we) begin
      armed_q <= 8'h00;
    end else if (stat_re) begin
      armed_q <= armed_q | flag_q;
    end
  end

  // ==========================================================================
  // Request gating
  // ==========================================================================
  // overflow gate
  assign overflow_irq   = flag_q[`TIG_B_OVF] & ien_q[`TIG_B_OVF];
  assign underflow_irq  = flag_q[`TIG_B_UNF] & ien_q[`TIG_B_UNF];
  assign match_d_irq    = flag_q[`TIG_B_MD] & ien_q[`TIG_B_MD];
  assign match_c_irq    = flag_q[`TIG_B_MC] & ien_q[`TIG_B_MC];
  assign match_b_irq    = flag_q[`TIG_B_MB] & ien_q[`TIG_B_MB];
  assign match_a_irq    = flag_q[`TIG_B_MA] & ien_q[`TIG_B_MA];
  assign conv_start_req = cap_a & ien_q[`TIG_B_CONV];

  assign ien  = ien_q;
  assign stat = flag_q | STAT_FIX;
  assign cnt  = cnt_q;

endmodule

/* File: verification/tig_props.sv */
// Port checks of the timer interrupt enable block.
`timescale 1ns/1ps
// ==========================================================
// Checker
module tig_props
  import tig_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [3:0] addr,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire tig_step_t  step [3],
  input wire logic [2:0] cap_a,
  input wire logic [2:0] conv_start_req,
  input wire logic [2:0] overflow_irq,
  input wire logic [2:0] underflow_irq,
  input wire logic [2:0] match_a_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_rd0;
    rd && addr == 4'h0 ##1 1'b1;
  endsequence
  sequence s_rd12;
    rd && (addr == 4'h1 || addr == 4'h2) ##1 1'b1;
  endsequence
  a_conv_needs_cap: assert property (
    conv_start_req != 3'h0 |-> (conv_start_req & ~cap_a) == 3'h0) else $error("conv without A");
  a_rsv_bits_ch0: assert property (
    s_rd0 |-> rdata[6] && !rdata[5]) else $error("ch0 reserved bits wrong");
  a_rsv_bits_ch12: assert property (
    s_rd12 |-> rdata[6] && rdata[3:2] == 2'h0) else $error("ch1/2 reserved bits wrong");
  a_no_unf_ch0: assert property (
    !underflow_irq[0]) else $error("ch0 underflow request");
  a_irq_holds: assert property (
    !wr && match_a_irq != 3'h0 |=> (match_a_irq & $past(match_a_irq)) == $past(match_a_irq))
    else $error("match A request dropped");
  a_match_cause: assert property (
    $rose(match_a_irq[0]) |-> $past(cap_a[0]) || $past(wr)) else $error("match A rose alone");
  a_ovf_cause: assert property (
    $rose(overflow_irq[1]) |-> $past(step[1]) == TIG_STEP_UP || $past(wr))
    else $error("overflow rose alone");
  a_unf_cause: assert property (
    $rose(underflow_irq[1]) |-> $past(step[1]) == TIG_STEP_DOWN || $past(wr))
    else $error("underflow rose alone");
endmodule
bind tig_top tig_props u_props (.clk, .rst_b, .addr, .wr, .rd, .rdata, .step, .cap_a,
  .conv_start_req, .overflow_irq, .underflow_irq, .match_a_irq);

/* File: verification/tig_sink.sv */
// Model of the converter trigger that takes the start requests.
`timescale 1ns/1ps
// ==========================================================
// Request sink
module tig_sink (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [2:0] conv_start_req,
  output int              conv_cnt
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) conv_cnt <= 0;
    else conv_cnt <= conv_cnt + $countones(conv_start_req);
  end
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench of the timer interrupt enable block.
`timescale 1ns/1ps
// ==========================================================
// Bench
module tb_top;
  import tig_pkg::*;
  logic       clk, rst_b, wr, rd, cap_c, cap_d, irq, mc, md;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [2:0] cap_a, cap_b, conv, ovf, unf, ma, mb;
  tig_step_t  step [3];
  int         err_total, total_checks, conv_cnt;
  tig_top dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .step(step), .cap_a(cap_a), .cap_b(cap_b), .cap_c(cap_c),
    .cap_d(cap_d), .conv_start_req(conv), .overflow_irq(ovf), .underflow_irq(unf),
    .match_a_irq(ma), .match_b_irq(mb), .match_c_irq(mc), .match_d_irq(md), .irq(irq));
  tig_sink u_sink (.clk(clk), .rst_b(rst_b), .conv_start_req(conv), .conv_cnt(conv_cnt));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e, nm);
  endtask
  task automatic ev(input logic [2:0] a, input logic c, input tig_step_t s1);
    @(posedge clk);
    cap_a <= a;
    cap_b <= a;
    cap_c <= c;
    cap_d <= c;
    step[1] <= s1;
    @(posedge clk);
    cap_a <= 3'h0;
    cap_b <= 3'h0;
    cap_c <= 1'b0;
    cap_d <= 1'b0;
    step[1] <= TIG_STEP_NONE;
    @(negedge clk);
  endtask
  task automatic t_regs();
    rd_chk(4'h4, 8'hC0, "stat0");
    rd_chk(4'h5, 8'h40, "stat1");
    rd_chk(4'hF, 8'h00, "unmapped");
    for (int i = 0; i < 3; i++) begin
      rd_chk(4'(i), 8'h40, "ien reset");
      wr_reg(4'(i), 8'hFF);
      rd_chk(4'(i), (i == 0) ? 8'hDF : 8'hF3, "ien mask");
      wr_reg(4'(i), 8'h00);
    end
  endtask
  task automatic t_wrap();
    wr_reg(4'h1, 8'h30);
    wr_reg(4'hD, 8'h02);
    ev(3'h0, 1'b0, TIG_STEP_DOWN);
    chk(8'(unf), 8'h02, "unf");
    chk(8'(irq), 8'h00, "irq masked");
    rd_chk(4'h9, 8'hFF, "cnt1 low");
    rd_chk(4'hD, 8'h02, "wrap mask");
    ev(3'h0, 1'b0, TIG_STEP_UP);
    chk(8'(ovf), 8'h02, "ovf");
    chk(8'(irq), 8'h01, "irq");
    rd_chk(4'hC, 8'h12, "wrap stat");
    chk(8'(irq), 8'h00, "irq clr");
    wr_reg(4'h1, 8'h00);
    chk(8'({ovf, unf}), 8'h00, "gated off");
  endtask
  task automatic t_match();
    ev(3'h3, 1'b1, TIG_STEP_NONE);
    chk(8'({ma, mb, mc, md}), 8'h00, "disabled");
    wr_reg(4'h0, 8'h0F);
    chk(8'({ma, mb, mc, md}), 8'h27, "enabled");
    wr_reg(4'h4, 8'h00);
    chk(8'({ma, mb, mc, md}), 8'h27, "unarmed clear");
    rd_chk(4'h4, 8'hCF, "stat0 set");
    wr_reg(4'h4, 8'hC0);
    chk(8'({ma, mb, mc, md}), 8'h00, "cleared");
    wr_reg(4'h1, 8'h02);
    chk(8'(mb), 8'h02, "ch1 B");
  endtask
  task automatic t_conv();
    for (int i = 0; i < 2; i++) begin
      wr_reg(4'h1, (i == 0) ? 8'h80 : 8'h00);
      @(posedge clk);
      cap_a <= 3'h2;
      @(negedge clk);
      chk(8'(conv), (i == 0) ? 8'h02 : 8'h00, "conv");
      @(posedge clk);
      cap_a <= 3'h0;
      @(negedge clk);
      chk(8'(conv_cnt), 8'h01, "conv count");
    end
  endtask
  task automatic conclude();
    $display("Checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    conclude();
  end
  initial begin
    {rst_b, wr, rd, cap_a, cap_b, cap_c, cap_d, addr, wdata} = '0;
    step = '{TIG_STEP_NONE, TIG_STEP_NONE, TIG_STEP_NONE};
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_wrap();
    t_match();
    t_conv();
    conclude();
  end
endmodule
